/* File: dv/ebs_mem_model.sv */
// behavioural external memory answering the bus strobes
`timescale 1ns/10ps
module ebs_mem_model (
   input  wire logic        ref_clk_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   input  wire logic        acc_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [3:0]  waits_i,
   output logic             ready_o,
   output logic [15:0]      rdata_o,
   output logic [15:0]      wword_o
);
   logic [3:0]  cnt_reg = 4'h0;
   logic [15:0] last_reg = 16'h0000;
   initial begin
      ready_o = 1'b1;
      wword_o = 16'h0000;
   end
   // data stands while the read strobe is low; a released bus shows the inverse
   assign rdata_o = !rd_n_i ? (addr_i ^ 16'h5a5a) : ~last_reg;
   // ready is held low ahead of a slow cycle: the pin reaches the core two edges late
   always @(posedge ref_clk_i) begin
      cnt_reg <= acc_n_i ? 4'h0 : cnt_reg + 4'h1;
      ready_o <= (!acc_n_i && (cnt_reg + 4'h1 >= waits_i)) || waits_i == 4'h0;
      if (!rd_n_i) begin
         last_reg <= addr_i ^ 16'h5a5a;
      end
      if (!wr_n_i) begin
         wword_o <= wdata_i;
      end
   end
endmodule // ebs_mem_model

/* File: dv/external_bus_strobe_control_test.sv */
// self-checking bench for the external bus strobe control block
`timescale 1ns/10ps
`include "ebs_params.svh"
module external_bus_strobe_control_test;
   import ebs_pkg::*;
   logic ref_clk_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0, flag_i = 1'b0;
   logic external_interface_enable_i = 1'b1, output_disable_n_i = 1'b1, test_reset_i = 1'b0;
   ebs_space_t req_space_i = EBS_SP_PROG;
   logic [15:0] req_addr_i = 16'h0000, req_wdata_i = 16'h0000, data_i, rdata_o, addr_o, data_o;
   logic [15:0] system_control_reg_two_o, wword, cnt [8];
   logic        ready_i, boot_flag_i, busy_o, done_o, scan_mode_o, rw_n_o, read_n_o;
   logic        program_space_select_n_o, data_space_select_n_o, io_space_select_n_o;
   logic        write_n_o, external_access_strobe_n_o, ctrl_oe_o, data_oe_o;
   logic        boot_flag_o, boot_flag_oe_o, got_done;
   logic [7:0]  lo;
   logic [3:0]  waits = 4'h0;
   int          err_total = 0, n_tests = 0;
   // boot pin carries an external pull-up strap until the device drives it
   assign boot_flag_i = (boot_flag_oe_o === 1'b1) ? boot_flag_o : 1'b1;
   always #50 ref_clk_i = ~ref_clk_i;
   ebs_strobe_ctrl dut (.ref_clk_i, .rstn_i, .req_i, .req_write_i, .req_space_i, .req_addr_i,
      .req_wdata_i, .flag_i, .ready_i, .external_interface_enable_i, .output_disable_n_i,
      .test_reset_i, .boot_flag_i, .data_i, .busy_o, .done_o, .rdata_o, .scan_mode_o,
      .system_control_reg_two_o, .program_space_select_n_o, .data_space_select_n_o,
      .io_space_select_n_o, .rw_n_o, .read_n_o, .write_n_o, .external_access_strobe_n_o,
      .ctrl_oe_o, .addr_o, .data_o, .data_oe_o, .boot_flag_o, .boot_flag_oe_o);
   ebs_mem_model mem (.ref_clk_i, .rd_n_i(read_n_o), .wr_n_i(write_n_o),
      .acc_n_i(external_access_strobe_n_o), .addr_i(ctrl_oe_o ? addr_o : ~addr_o),
      .wdata_i(data_oe_o ? data_o : ~data_o), .waits_i(waits), .ready_o(ready_i),
      .rdata_o(data_i), .wword_o(wword));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge ref_clk_i);
      #10;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one request, then count low cycles of every strobe until done or a bound
   task automatic run_cycle(input ebs_space_t sp, input logic wr, input logic [3:0] w);
      waits = w;
      foreach (cnt[k]) cnt[k] = 16'h0000;
      repeat (3) step();
      req_space_i = sp;
      req_write_i = wr;
      req_addr_i = {12'ha50, 2'h0, sp};
      req_wdata_i = ~req_addr_i;
      req_i = 1'b1;
      step();
      req_i = 1'b0;
      got_done = 1'b0;
      for (int i = 0; i < 30 && !got_done; i++) begin
         lo = {busy_o === 1'b1, external_access_strobe_n_o === 1'b0, write_n_o === 1'b0,
               read_n_o === 1'b0, rw_n_o === 1'b0, io_space_select_n_o === 1'b0,
               data_space_select_n_o === 1'b0, program_space_select_n_o === 1'b0};
         foreach (cnt[k]) cnt[k] += {15'h0000, lo[k] & (k == 7 || ctrl_oe_o === 1'b1)};
         got_done = (done_o === 1'b1);
         step();
      end
      step();
      waits = 4'h0;
   endtask
   task automatic test_boot();
      check("strap bit", system_control_reg_two_o, 16'h0008);
      check("flag oe", 16'(boot_flag_oe_o), 16'h0001);
      check("flag low", 16'(boot_flag_o), 16'h0000);
      check("idle strobe", 16'(external_access_strobe_n_o), 16'h0001);
      flag_i = 1'b1;
      repeat (2) step();
      check("flag high", 16'(boot_flag_o), 16'h0001);
      flag_i = 1'b0;
      $display("boot test done");
   endtask
   task automatic test_access();
      for (int w = 0; w < 2; w++) begin
         for (int s = 0; s < 3; s++) begin
            run_cycle(ebs_space_t'(s), w[0], 4'h0);
            check("program sel", cnt[0], 16'(s == 0));
            check("data sel", cnt[1], 16'(s == 1));
            check("io sel", cnt[2], 16'(s == 2));
            check("rw qual", cnt[3], 16'(w));
            check("read strobe", cnt[4], 16'(w == 0));
            check("write strobe", cnt[5], 16'(w));
            check("access strobe", cnt[6], 16'h0001);
            check("done", 16'(got_done), 16'h0001);
            if (w == 1) check("written", wword, req_wdata_i);
            else check("read data", rdata_o, req_addr_i ^ 16'h5a5a);
         end
      end
      $display("access test done");
   endtask
   task automatic test_waits();
      run_cycle(EBS_SP_DATA, 1'b0, 4'h4);
      check("wait span", 16'(cnt[6] >= 16'h0005), 16'h0001);
      check("wait done", 16'(got_done), 16'h0001);
      check("wait data", rdata_o, req_addr_i ^ 16'h5a5a);
      $display("wait test done");
   endtask
   task automatic test_refuse();
      external_interface_enable_i = 1'b0;
      repeat (4) step();
      check("ctrl oe off", 16'(ctrl_oe_o), 16'h0000);
      run_cycle(EBS_SP_IO, 1'b1, 4'h0);
      check("busy disabled", cnt[7], 16'h0000);
      external_interface_enable_i = 1'b1;
      test_reset_i = 1'b1;
      repeat (4) step();
      check("scan on", 16'(scan_mode_o), 16'h0001);
      run_cycle(EBS_SP_PROG, 1'b0, 4'h0);
      check("busy scan", cnt[7], 16'h0000);
      test_reset_i = 1'b0;
      repeat (4) step();
      check("scan off", 16'(scan_mode_o), 16'h0000);
      $display("refuse test done");
   endtask
   task automatic test_off();
      output_disable_n_i = 1'b0;
      repeat (4) step();
      check("off ctrl oe", 16'(ctrl_oe_o), 16'h0000);
      check("off data oe", 16'(data_oe_o), 16'h0000);
      check("off flag oe", 16'(boot_flag_oe_o), 16'h0000);
      output_disable_n_i = 1'b1;
      repeat (4) step();
      check("on flag oe", 16'(boot_flag_oe_o), 16'h0001);
      $display("disable test done");
   endtask
   initial begin
      // three edges of reset: the strap runs through the synchroniser meanwhile
      repeat (3) step();
      rstn_i = 1'b1;
      repeat (3) step();
      test_boot();
      test_access();
      test_waits();
      test_refuse();
      test_off();
      report_and_stop();
   end
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
endmodule // external_bus_strobe_control_test

/* File: rtl/ebs_params.svh */
// constants for the external bus strobe control block
// Operation
// (R1) program select low only during program access
// (R2) data select low only during data access
// (R3) io select low only during io access
// (R4) read/write qualifier low only during writes
// (R5) read strobe low on every external read
// (R6) output disable low tristates all outputs
// (R7) test reset high gives scan control
// (R8) boot pin sampled in reset, then flag
// (R9) write strobe low on every external write
// (R10) access strobe low on every bus cycle
// (R11) ready low adds one-cycle wait states
// (R12) interface enable high enables bus signals
// (R13) disabled interface tristates strobes and qualifier
`ifndef EBS_PARAMS_SVH
`define EBS_PARAMS_SVH
`define EBS_BOOT_BIT    3
`define EBS_SCR_W       16
`define EBS_SCR_RESET   16'h0000
`define EBS_ADDR_W      16
`define EBS_DATA_W      16
`define EBS_SYNC_RESET  4'h4
`endif

/* File: rtl/ebs_pin_sync.sv */
// two-flop synchronisers for the asynchronous control pins
`timescale 1ns/10ps
`include "ebs_params.svh"
module ebs_pin_sync (
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   input  wire logic ready_i,
   input  wire logic enable_i,
   input  wire logic off_n_i,
   input  wire logic trst_i,
   input  wire logic boot_i,
   ebs_sync_if.src   sync
);
   logic [4:0] meta_reg;
   logic [4:0] meta_next;
   logic [4:0] stab_reg;
   logic [4:0] stab_next;

   always_comb begin
      meta_next = {boot_i, trst_i, off_n_i, enable_i, ready_i};
      stab_next = meta_reg;
   end

   // reset values keep outputs on and test mode off; the strap bit keeps
   // running through reset so its level is settled before release
   always_ff @(posedge ref_clk_i) begin
      meta_reg[4] <= meta_next[4];
      stab_reg[4] <= stab_next[4];
      if (!rstn_i) begin
         meta_reg[3:0] <= `EBS_SYNC_RESET;
         stab_reg[3:0] <= `EBS_SYNC_RESET;
      end else begin
         meta_reg[3:0] <= meta_next[3:0];
         stab_reg[3:0] <= stab_next[3:0];
      end
   end

   assign sync.ready  = stab_reg[0];
   assign sync.enable = stab_reg[1];
   assign sync.off_n  = stab_reg[2];
   assign sync.trst   = stab_reg[3];
   assign sync.boot   = stab_reg[4];
endmodule // ebs_pin_sync

/* File: rtl/ebs_pkg.sv */
// types for the external bus strobe control block
package ebs_pkg;
   typedef enum logic [1:0] {
      EBS_SP_PROG = 2'h0,
      EBS_SP_DATA = 2'h1,
      EBS_SP_IO   = 2'h2
   } ebs_space_t;

   typedef enum logic [1:0] {
      EBS_IDLE   = 2'h0,
      EBS_ACCESS = 2'h1,
      EBS_DONE   = 2'h3
   } ebs_state_t;
endpackage

/* File: rtl/ebs_strobe_ctrl.sv */
// external bus strobe sequencer and pin control
`timescale 1ns/10ps
`include "ebs_params.svh"
module ebs_strobe_ctrl (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    req_i,
   input  wire logic                    req_write_i,
   input  ebs_pkg::ebs_space_t          req_space_i,
   input  wire logic [`EBS_ADDR_W-1:0]  req_addr_i,
   input  wire logic [`EBS_DATA_W-1:0]  req_wdata_i,
   input  wire logic                    flag_i,
   input  wire logic                    ready_i,
   input  wire logic                    external_interface_enable_i,
   input  wire logic                    output_disable_n_i,
   input  wire logic                    test_reset_i,
   input  wire logic                    boot_flag_i,
   input  wire logic [`EBS_DATA_W-1:0]  data_i,
   output logic                         busy_o,
   output logic                         done_o,
   output logic [`EBS_DATA_W-1:0]       rdata_o,
   output logic                         scan_mode_o,
   output logic [`EBS_SCR_W-1:0]        system_control_reg_two_o,
   output logic                         program_space_select_n_o,
   output logic                         data_space_select_n_o,
   output logic                         io_space_select_n_o,
   output logic                         rw_n_o,
   output logic                         read_n_o,
   output logic                         write_n_o,
   output logic                         external_access_strobe_n_o,
   output logic                         ctrl_oe_o,
   output logic [`EBS_ADDR_W-1:0]       addr_o,
   output logic [`EBS_DATA_W-1:0]       data_o,
   output logic                         data_oe_o,
   output logic                         boot_flag_o,
   output logic                         boot_flag_oe_o
);
   import ebs_pkg::*;

   ebs_sync_if sy ();

   ebs_pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .ready_i   (ready_i),
      .enable_i  (external_interface_enable_i),
      .off_n_i   (output_disable_n_i),
      .trst_i    (test_reset_i),
      .boot_i    (boot_flag_i),
      .sync      (sy.src)
   );

   // ***********************************************************
   // bus sequencer
   // ***********************************************************
   ebs_state_t               st_reg,  st_next;
   ebs_space_t               sp_reg,  sp_next;
   logic                     wr_reg,  wr_next;
   logic [`EBS_ADDR_W-1:0]   ad_reg,  ad_next;
   logic [`EBS_DATA_W-1:0]   wd_reg,  wd_next;
   logic [`EBS_DATA_W-1:0]   rd_reg,  rd_next;
   logic                     dn_reg,  dn_next;
   logic                     bz_reg,  bz_next;
   logic                     run;

   function automatic logic sel_n(input logic act, input ebs_space_t s, input ebs_space_t w);
      sel_n = !(act && (s == w));
   endfunction

   // a disabled interface or scan control holds off new cycles
   assign run = sy.enable && !sy.trst; // see (R12) see (R7)

   always_comb begin
      st_next = st_reg;
      sp_next = sp_reg;
      wr_next = wr_reg;
      ad_next = ad_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      dn_next = 1'b0;
      case (st_reg)
         EBS_IDLE: begin
            if (req_i && run) begin
               st_next = EBS_ACCESS;
               sp_next = req_space_i;
               wr_next = req_write_i;
               ad_next = req_addr_i;
               wd_next = req_wdata_i;
            end
         end
         EBS_ACCESS: begin
            // ready low stretches the cycle, resampled each clock
            if (sy.ready) begin // see (R11)
               st_next = EBS_DONE;
               if (!wr_reg) begin
                  rd_next = data_i;
               end
               dn_next = 1'b1;
            end
         end
         EBS_DONE: begin
            st_next = EBS_IDLE;
         end
         default: begin
            st_next = EBS_IDLE;
         end
      endcase
      bz_next = (st_next != EBS_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st_reg <= EBS_IDLE;
         sp_reg <= EBS_SP_PROG;
         wr_reg <= 1'b0;
         ad_reg <= '0;
         wd_reg <= '0;
         rd_reg <= '0;
         dn_reg <= 1'b0;
         bz_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sp_reg <= sp_next;
         wr_reg <= wr_next;
         ad_reg <= ad_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
         dn_reg <= dn_next;
         bz_reg <= bz_next;
      end
   end

   // ***********************************************************
   // pin drivers
   // ***********************************************************
   logic       act_next;
   logic       ps_n_reg, ds_n_reg, is_n_reg, rw_reg, rdn_reg, wrn_reg, acc_reg;
   logic       ps_n_next, ds_n_next, is_n_next, rw_next, rdn_next, wrn_next, acc_next;
   logic       coe_reg, coe_next, doe_reg, doe_next;
   logic [`EBS_ADDR_W-1:0] ao_reg;
   logic [`EBS_DATA_W-1:0] do_reg;

   always_comb begin
      act_next  = (st_next == EBS_ACCESS);
      ps_n_next = sel_n(act_next, sp_next, EBS_SP_PROG);   // see (R1)
      ds_n_next = sel_n(act_next, sp_next, EBS_SP_DATA);   // see (R2)
      is_n_next = sel_n(act_next, sp_next, EBS_SP_IO);     // see (R3)
      rw_next   = !(act_next && wr_next);                  // see (R4)
      rdn_next  = !(act_next && !wr_next);                 // see (R5)
      wrn_next  = !(act_next && wr_next);                  // see (R9)
      acc_next  = !act_next;                               // see (R10)
      // off pin overrides everything; the enable releases only the bus
      coe_next  = sy.off_n && sy.enable;                   // see (R6) see (R13)
      doe_next  = coe_next && act_next && wr_next;         // see (R9)
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ps_n_reg <= 1'b1;
         ds_n_reg <= 1'b1;
         is_n_reg <= 1'b1;
         rw_reg   <= 1'b1;
         rdn_reg  <= 1'b1;
         wrn_reg  <= 1'b1;
         acc_reg  <= 1'b1;
         coe_reg  <= 1'b0;
         doe_reg  <= 1'b0;
         ao_reg   <= '0;
         do_reg   <= '0;
      end else begin
         ps_n_reg <= ps_n_next;
         ds_n_reg <= ds_n_next;
         is_n_reg <= is_n_next;
         rw_reg   <= rw_next;
         rdn_reg  <= rdn_next;
         wrn_reg  <= wrn_next;
         acc_reg  <= acc_next;
         coe_reg  <= coe_next;
         doe_reg  <= doe_next;
         ao_reg   <= ad_next;
         do_reg   <= wd_next;
      end
   end

   // ***********************************************************
   // boot strap and flag pin
   // ***********************************************************
   logic [`EBS_SCR_W-1:0] scr_reg, scr_next;
   logic                  flg_reg, flg_next, foe_reg, foe_next, scan_reg, scan_next;

   // the strap is caught by the clock while reset is held, not by the reset itself
   always_comb begin
      scr_next  = scr_reg;
      flg_next  = flag_i;
      foe_next  = sy.off_n;                                // see (R6)
      scan_next = sy.trst;                                 // see (R7)
      if (!rstn_i) begin
         scr_next = `EBS_SCR_RESET;
         scr_next[`EBS_BOOT_BIT] = sy.boot;                // see (R8)
         foe_next = 1'b0;                                  // see (R8)
      end
   end

   always_ff @(posedge ref_clk_i) begin
      scr_reg <= scr_next;
      if (!rstn_i) begin
         flg_reg  <= 1'b0;
         foe_reg  <= 1'b0;
         scan_reg <= 1'b0;
      end else begin
         flg_reg  <= flg_next;
         foe_reg  <= foe_next;
         scan_reg <= scan_next;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign busy_o                     = bz_reg;
   assign done_o                     = dn_reg;
   assign rdata_o                    = rd_reg;
   assign scan_mode_o                = scan_reg;
   assign system_control_reg_two_o   = scr_reg;
   assign program_space_select_n_o   = ps_n_reg;
   assign data_space_select_n_o      = ds_n_reg;
   assign io_space_select_n_o        = is_n_reg;
   assign rw_n_o                     = rw_reg;
   assign read_n_o                   = rdn_reg;
   assign write_n_o                  = wrn_reg;
   assign external_access_strobe_n_o = acc_reg;
   assign ctrl_oe_o                  = coe_reg;
   assign addr_o                     = ao_reg;
   assign data_o                     = do_reg;
   assign data_oe_o                  = doe_reg;
   assign boot_flag_o                = flg_reg;
   assign boot_flag_oe_o             = foe_reg;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   a_prog_sel_cause: assert property (!ps_n_reg |-> !acc_reg && sp_reg == EBS_SP_PROG) // see (R1)
      else $error("program select without program access");
   a_data_sel_cause: assert property (!ds_n_reg |-> !acc_reg && sp_reg == EBS_SP_DATA) // see (R2)
      else $error("data select without data access");
   a_io_sel_cause: assert property (!is_n_reg |-> !acc_reg && sp_reg == EBS_SP_IO) // see (R3)
      else $error("io select without io access");
   a_rw_write_only: assert property (!rw_reg |-> wr_reg && !wrn_reg && rdn_reg) // see (R4)
      else $error("qualifier low outside a write");
   a_read_strobe: assert property (!acc_reg && !wr_reg |-> !rdn_reg && wrn_reg) // see (R5)
      else $error("read cycle without read strobe");
   a_off_tristate: assert property (!sy.off_n |=> !coe_reg && !foe_reg) // see (R6)
      else $error("outputs driven while disabled");
   a_scan_blocks: assert property (sy.trst && st_reg == EBS_IDLE |=> st_reg == EBS_IDLE) // see (R7)
      else $error("cycle started under scan control");
   a_flag_drive: assert property ($rose(rstn_i) |-> scr_reg[`EBS_BOOT_BIT] == $past(sy.boot)
      ##1 foe_reg == $past(sy.off_n)) // see (R8)
      else $error("flag pin not driven after reset");
   a_ready_wait: assert property (st_reg == EBS_ACCESS && !sy.ready |=> st_reg == EBS_ACCESS && !acc_reg) // see (R11)
      else $error("wait state not held");
   a_strobe_span: assert property (!acc_reg |-> (!ps_n_reg || !ds_n_reg || !is_n_reg)) // see (R10)
      else $error("access strobe without space select");
   a_disable_release: assert property (!sy.enable |=> !coe_reg && !doe_reg) // see (R13)
      else $error("bus driven while interface disabled");

   c_read: cover property (!rdn_reg ##1 rdn_reg);
   c_write: cover property (!wrn_reg && doe_reg);
   c_wait: cover property (st_reg == EBS_ACCESS ##1 st_reg == EBS_ACCESS ##1 st_reg == EBS_DONE);
   c_io: cover property (!is_n_reg);
endmodule // ebs_strobe_ctrl

/* File: rtl/ebs_sync_if.sv */
// interface carrying synchronised pin levels to the core
`timescale 1ns/10ps
interface ebs_sync_if;
   logic ready;
   logic enable;
   logic off_n;
   logic trst;
   logic boot;
   modport src (output ready, output enable, output off_n, output trst, output boot);
   modport dst (input ready, input enable, input off_n, input trst, input boot);
endinterface
